// ==== wwd_pkg.sv ====
// Constants for the windowed watchdog timer: register map, field positions,
// reset values and timing counts.
// Assumes one 50 MHz core clock and a classic Wishbone register port.
//
// How it works
// [RL1] Always-on config bit set: watchdog runs always, software enable ignored.
// [RL2] Always-on bit clear: watchdog runs only while software enable is set.
// [RL3] Every device reset clears the software enable bit.
// [RL4] Window-disable bit 6: one means plain mode, zero means window mode.
// [RL5] Prescale select one divides by 128, zero divides by 32.
// [RL6] Prescaler is a 5-bit or 7-bit counter chosen by prescale select.
// [RL7] From 32 kHz the prescaler alone gives about 1 ms or 4 ms.
// [RL8] Postscaler divides prescaler output, 4-bit field bits 3..0, sixteen ratios.
// [RL9] Completed clock switch resets counter, prescaler and postscaler.
// [RL10] Clear, power-save, device reset and low-power exit reset the counts.
// [RL11] An enabled watchdog keeps counting in sleep and idle.
// [RL12] Time-out in sleep or idle wakes the core, which resumes execution.
// [RL13] Software clears the sleep and idle flags itself after wake-up.
// [RL14] Window mode: a clear before the final quarter causes a watchdog reset.
// [RL15] Time-out flag stays set until software clears it.
// [RL16] An enabled watchdog switches its low-power RC clock on.
// [RL17] Postscale code n divides by two to the power n.
// [RL18] Time-out outside low power raises reset request and flag together.

package wwd_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_ALWAYS_ON = 7;
  localparam int CFG_WIN_DIS = 6;
  localparam int CFG_PRE_SEL = 4;
  localparam int CTRL_SW_EN = 5;
  localparam int CTRL_TIMEOUT = 4;
  localparam int CTRL_SLEEP = 3;
  localparam int CTRL_IDLE = 2;
  localparam int CMD_CLEAR = 0;
  localparam int CMD_SLEEP = 1;
  localparam int CMD_IDLE = 2;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_WINDOW = 1;
  localparam int IRQ_WAKE = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] CFG_RST = 8'h5F;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int RC_OSC_HZ = 32_000;
  localparam int RC_DIV_DEF = CLK_HZ / RC_OSC_HZ;
  localparam logic [6:0] PRE_SHORT_LAST = 7'h1F;
  localparam logic [6:0] PRE_LONG_LAST = 7'h7F;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE} wwd_pwr_e;

endpackage

// ==== wwd_top.sv ====
// Windowed watchdog timer with prescaler, postscaler and low-power wake.
// Assumes a classic Wishbone master on core_clk and strobes from core logic
// on the same clock.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/100ps

module wwd_top
  import wwd_pkg::*;
#(
  parameter int RC_DIV = RC_DIV_DEF
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core events
  input wire logic clk_switch_done,
  input wire logic ext_wake,
  // Outputs to the system
  output logic device_reset_req,
  output logic core_wake,
  output logic sleep_active,
  output logic idle_active,
  output logic low_power_rc_osc,
  output logic irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [14:0] post_last(input logic [3:0] code);
    logic [15:0] ratio;
    ratio = 16'h0001 << code;
    post_last = 15'(ratio - 16'h0001);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] watchdog_configuration;
  logic software_wd_enable;
  logic wd_timeout_flag;
  logic sleep_flag;
  logic idle_flag;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [10:0] div_cnt;
  logic [6:0] pre_cnt;
  logic [14:0] post_cnt;
  wwd_pwr_e pwr;
  wwd_pwr_e next_pwr;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_cfg = bus_wr && wb_adr_i == OFS_CFG;
  wire wr_ctrl = bus_wr && wb_adr_i == OFS_CTRL;
  wire wr_cmd = bus_wr && wb_adr_i == OFS_CMD;
  wire wr_stat = bus_wr && wb_adr_i == OFS_IRQ_STAT;
  wire wr_mask = bus_wr && wb_adr_i == OFS_IRQ_MASK;

  // ----------------------------------------
  // Enable and commands
  // ----------------------------------------
  wire always_on_cfg = watchdog_configuration[CFG_ALWAYS_ON];
  wire window_disable_cfg = watchdog_configuration[CFG_WIN_DIS];
  wire prescale_select_cfg = watchdog_configuration[CFG_PRE_SEL];
  wire [3:0] postscale_select_cfg = watchdog_configuration[3:0];
  wire wd_on = always_on_cfg | software_wd_enable; // [RL1] [RL2]
  wire in_low_power = pwr != PWR_RUN;
  wire wd_clear_instr = wr_cmd & wb_dat_i[CMD_CLEAR] & ~in_low_power;
  wire save_sleep = wr_cmd & wb_dat_i[CMD_SLEEP] & ~in_low_power;
  wire save_idle = wr_cmd & wb_dat_i[CMD_IDLE] & ~in_low_power & ~wb_dat_i[CMD_SLEEP];
  wire power_save_instr = save_sleep | save_idle;

  // ----------------------------------------
  // Counting chain
  // ----------------------------------------
  wire lp_tick = wd_on && div_cnt == 11'(RC_DIV - 1); // [RL7]
  wire [6:0] pre_last = prescale_select_cfg ? PRE_LONG_LAST : PRE_SHORT_LAST; // [RL5] [RL6]
  wire pre_wrap = lp_tick && pre_cnt == pre_last;
  wire [14:0] post_lim = post_last(postscale_select_cfg); // [RL17]
  wire expire = pre_wrap && post_cnt == post_lim; // [RL8]

  // ----------------------------------------
  // Window check
  // ----------------------------------------
  wire [21:0] elapsed = prescale_select_cfg ? {post_cnt, pre_cnt} : {2'b00, post_cnt, pre_cnt[4:0]};
  wire [21:0] period_m1 = prescale_select_cfg ? {post_lim, PRE_LONG_LAST} : {2'b00, post_lim, 5'(PRE_SHORT_LAST)};
  wire [22:0] period = {1'b0, period_m1} + 23'h000001;
  wire [22:0] win_start = period - (period >> 2);
  wire too_early = {1'b0, elapsed} < win_start;
  wire win_fault = wd_clear_instr & wd_on & ~window_disable_cfg & too_early; // [RL4] [RL14]

  // ----------------------------------------
  // Events
  // ----------------------------------------
  wire wake = in_low_power & (expire | ext_wake); // [RL11] [RL12]
  wire to_reset = (expire & ~in_low_power) | win_fault; // [RL18]
  wire cnt_rst = wd_clear_instr | power_save_instr | wake | clk_switch_done | expire | ~wd_on; // [RL9] [RL10]
  wire [2:0] irq_set = {wake, win_fault, expire};

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] ctrl_rd = {2'b00, software_wd_enable, wd_timeout_flag, sleep_flag, idle_flag, 2'b00};
  wire [31:0] rd_data =
    wb_adr_i == OFS_CFG ? {24'h000000, watchdog_configuration} :
    wb_adr_i == OFS_CTRL ? {24'h000000, ctrl_rd} :
    wb_adr_i == OFS_IRQ_STAT ? {29'h00000000, irq_stat} :
    wb_adr_i == OFS_IRQ_MASK ? {29'h00000000, irq_mask} :
    wb_adr_i == OFS_COUNT ? {17'h00000, post_cnt} :
    32'h00000000;

  // ----------------------------------------
  // Power mode
  // ----------------------------------------
  always_comb
  begin
    next_pwr = pwr;
    unique case (pwr)
      PWR_RUN:
      begin
        if (save_sleep)
          next_pwr = PWR_SLEEP;
        else if (save_idle)
          next_pwr = PWR_IDLE;
      end
      PWR_SLEEP, PWR_IDLE:
      begin
        if (wake)
          next_pwr = PWR_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      watchdog_configuration <= CFG_RST;
      software_wd_enable <= 1'b0; // [RL3]
      irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      if (wr_cfg)
        watchdog_configuration <= wb_dat_i[7:0];
      if (wr_ctrl)
        software_wd_enable <= wb_dat_i[CTRL_SW_EN];
      if (wr_mask)
        irq_mask <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wd_timeout_flag <= 1'b0;
      sleep_flag <= 1'b0;
      idle_flag <= 1'b0;
      irq_stat <= 3'h0;
    end
    else
    begin
      wd_timeout_flag <= (expire | win_fault) | (wd_timeout_flag & ~(wr_ctrl & wb_dat_i[CTRL_TIMEOUT])); // [RL15]
      sleep_flag <= save_sleep | (sleep_flag & ~(wr_ctrl & wb_dat_i[CTRL_SLEEP])); // [RL13]
      idle_flag <= save_idle | (idle_flag & ~(wr_ctrl & wb_dat_i[CTRL_IDLE])); // [RL13]
      irq_stat <= irq_set | (irq_stat & ~(wr_stat ? wb_dat_i[2:0] : 3'h0));
    end
  end

  // ----------------------------------------
  // Divider, prescaler, postscaler
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_cnt <= 11'h000;
    else if (~wd_on || lp_tick)
      div_cnt <= 11'h000;
    else
      div_cnt <= div_cnt + 11'h001;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_cnt <= 7'h00;
      post_cnt <= 15'h0000;
    end
    else if (cnt_rst) // [RL9] [RL10]
    begin
      pre_cnt <= 7'h00;
      post_cnt <= 15'h0000;
    end
    else if (pre_wrap)
    begin
      pre_cnt <= 7'h00;
      post_cnt <= post_cnt + 15'h0001; // [RL8]
    end
    else if (lp_tick)
      pre_cnt <= pre_cnt + 7'h01; // [RL6] [RL11]
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwr <= PWR_RUN;
      device_reset_req <= 1'b0;
      core_wake <= 1'b0;
      sleep_active <= 1'b0;
      idle_active <= 1'b0;
      low_power_rc_osc <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      pwr <= next_pwr;
      device_reset_req <= to_reset; // [RL14] [RL18]
      core_wake <= wake; // [RL12]
      sleep_active <= next_pwr == PWR_SLEEP;
      idle_active <= next_pwr == PWR_IDLE;
      low_power_rc_osc <= wd_on; // [RL16]
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule

// ==== wwd_asserts.sv ====
// Checker on the watchdog top module ports.
// Assumes one core clock and the bind at the foot of this file.
`timescale 1ns/100ps
module wwd_chk
  import wwd_pkg::*;
(
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // System outputs
  input wire logic device_reset_req,
  input wire logic core_wake,
  input wire logic sleep_active,
  input wire logic idle_active,
  input wire logic low_power_rc_osc
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack held");
  property p_cmd0; wb_ack_o && !wb_we_i && wb_adr_i == OFS_CMD |-> wb_dat_o == 32'h0; endproperty
  a_cmd0: assert property (p_cmd0) else $error("cmd reads nonzero");
  property p_rst1; device_reset_req |=> !device_reset_req; endproperty
  a_rst1: assert property (p_rst1) else $error("reset req held");
  property p_rstrun; device_reset_req |-> !$past(sleep_active) && !$past(idle_active); endproperty
  a_rstrun: assert property (p_rstrun) else $error("reset req in low power");
  property p_rstosc; device_reset_req |-> $past(low_power_rc_osc); endproperty
  a_rstosc: assert property (p_rstosc) else $error("reset req while off");
  property p_wake; core_wake |-> !sleep_active && !idle_active; endproperty
  a_wake: assert property (p_wake) else $error("wake left mode");
  property p_wake1; core_wake |=> !core_wake; endproperty
  a_wake1: assert property (p_wake1) else $error("wake held");
  property p_excl; !(sleep_active && idle_active); endproperty
  a_excl: assert property (p_excl) else $error("both modes");
  c_rst: cover property (device_reset_req);
  c_wake: cover property (core_wake);
  c_slp: cover property (sleep_active);
endmodule
bind wwd_top wwd_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_wake(core_wake),
  .device_reset_req(device_reset_req), .sleep_active(sleep_active), .idle_active(idle_active),
  .low_power_rc_osc(low_power_rc_osc));

// ==== tb_top.sv ====
// Self-checking bench for the windowed watchdog timer.
// Assumes the checker is bound in; the RC divider is shortened to 2.
`timescale 1ns/100ps
module tb_top
  import wwd_pkg::*;
;
  localparam int LDIV = 2;
  logic core_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, csd = 0, ewk = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, dat_o;
  logic ack, rreq, wake, slp, idl, osc, irq;
  int err_count = 0, tests_run = 0, n;
  wwd_top #(.RC_DIV(LDIV)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .clk_switch_done(csd), .ext_wake(ewk), .device_reset_req(rreq), .core_wake(wake),
    .sleep_active(slp), .idle_active(idl), .low_power_rc_osc(osc), .irq(irq));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task finish_test();
    $display("runs %0d bad %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task wt(input bit w, input int lim);
    n = 0;
    while ((w ? wake : rreq) !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task t_per(input logic [7:0] c);
    int e;
    e = (c[4] ? 128 : 32) * (1 << c[3:0]) * LDIV;
    wr(OFS_CFG, {24'h0, c});
    wr(OFS_CMD, 32'h1);
    wt(0, 2 * e);
    rng(e - 2, e + 4);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_en();
    rd(OFS_CFG, 32'h5F);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_CMD, 32'h0);
    wr(OFS_CFG, 32'h40);
    chk(32'(osc), 32'h0);
    wr(OFS_CTRL, 32'h20);
    wr(OFS_IRQ_MASK, 32'h1);
    chk(32'(osc), 32'h1);
    t_per(8'h40);
    rd(OFS_CTRL, 32'h30);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    wr(OFS_CTRL, 32'h30);
    rd(OFS_CTRL, 32'h20);
    t_per(8'h50);
    t_per(8'h41);
    t_per(8'h43);
    repeat (66) @(posedge core_clk);
    rd(OFS_COUNT, 32'h1);
    wr(OFS_CTRL, 32'h10);
    wt(0, 400);
    chk(n, 400);
    $display("t_en end");
  endtask
  task t_win();
    wr(OFS_CFG, 32'hC0);
    wr(OFS_CTRL, 32'h0);
    chk(32'(osc), 32'h1);
    t_per(8'hC0);
    wr(OFS_CFG, 32'h80);
    wr(OFS_CMD, 32'h1);
    wr(OFS_CMD, 32'h1);
    wt(0, 6);
    rng(0, 5);
    rd(OFS_IRQ_STAT, 32'h3);
    repeat (53) @(posedge core_clk);
    wr(OFS_CMD, 32'h1);
    wt(0, 8);
    chk(n, 8);
    wr(OFS_CTRL, 32'h10);
    $display("t_win end");
  endtask
  task t_lp();
    wr(OFS_CFG, 32'h40);
    wr(OFS_CTRL, 32'h20);
    wr(OFS_CMD, 32'h1);
    wr(OFS_CMD, 32'h2);
    @(posedge core_clk);
    chk(32'(slp), 32'h1);
    wt(1, 200);
    rng(60, 70);
    rd(OFS_CTRL, 32'h38);
    wr(OFS_CTRL, 32'h38);
    wr(OFS_CMD, 32'h4);
    @(posedge core_clk);
    chk(32'(idl), 32'h1);
    ewk <= 1'b1;
    @(posedge core_clk);
    ewk <= 1'b0;
    wt(1, 4);
    rng(0, 3);
    rd(OFS_CTRL, 32'h24);
    wr(OFS_CTRL, 32'h24);
    wr(OFS_CMD, 32'h1);
    repeat (40) @(posedge core_clk);
    csd <= 1'b1;
    @(posedge core_clk);
    csd <= 1'b0;
    wt(0, 200);
    rng(62, 68);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    chk(32'(osc), 32'h0);
    $display("t_lp end");
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_en();
    t_win();
    t_lp();
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    finish_test();
  end
endmodule
